// *** shared/nfcr_consts.svh ***
// Constants of the oscillator and filter control register bank
// Behaviour
// R1: Six-bit third-stage mode field, reset code zero selects centred unmodulated band.
// R2: Codes 001001, 010010, 011011 keep input unmodulated and shift the band.
// R3: Codes 100100 to 111111 modulate the input by the stage input rate.
// R4: Bypass bit zero of third-stage control skips the third filter stage.
// R5: Read-only eight-bit identification register returning a fixed part code.
// R6: 32-bit carrier tuning word built from four bytes, lowest byte first.
// R7: Tuning byte writes are staged; frequency changes only on request rising edge.
// R8: Software toggles request zero then one; device transfers word on that edge.
// R9: After transfer the tuning load done bit reads one.
// R10: Armed sync reset resets the oscillator on the next extended sync pulse.
// R11: Sync reset done bit reads one after the oscillator was sync reset.
// R12: Oscillator reset loads a 16-bit two's-complement start phase, full turn.
// R13: Ten-bit I phase trim from low byte and two high bits is applied.
// R14: Ten-bit Q phase trim from low byte and two high bits is applied.
// R15: 16-bit I offset from two bytes is added to every I sample.
// R16: Holding the request bit high never repeats the tuning word transfer.
`ifndef NFCR_CONSTS_SVH
`define NFCR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define NFCR_IDX_STAGE    8'h1E
`define NFCR_IDX_ID       8'h1F
`define NFCR_IDX_TW0      8'h30
`define NFCR_IDX_TW1      8'h31
`define NFCR_IDX_TW2      8'h32
`define NFCR_IDX_TW3      8'h33
`define NFCR_IDX_PH_LO    8'h34
`define NFCR_IDX_PH_HI    8'h35
`define NFCR_IDX_UPD      8'h36
`define NFCR_IDX_ITRIM_LO 8'h38
`define NFCR_IDX_ITRIM_HI 8'h39
`define NFCR_IDX_QTRIM_LO 8'h3A
`define NFCR_IDX_QTRIM_HI 8'h3B
`define NFCR_IDX_IOFF_LO  8'h3C
`define NFCR_IDX_IOFF_HI  8'h3D
`define NFCR_IDX_IRQ_ST   8'h50
`define NFCR_IDX_IRQ_MSK  8'h51

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define NFCR_BIT_SKIP     0
`define NFCR_BIT_UPD_REQ  0
`define NFCR_BIT_UPD_ACK  1
`define NFCR_BIT_SYN_ARM  4
`define NFCR_BIT_SYN_DONE 5
`define NFCR_ST_LOAD      0
`define NFCR_ST_SYNC      1
`define NFCR_RST_BYTE     8'h00
`define NFCR_RESP_OKAY    2'h0
`define NFCR_RESP_SLVERR  2'h2

`endif

// *** shared/nfcr_pkg.sv ***
// Types shared by the oscillator and filter control register bank
`default_nettype none
package nfcr_pkg;
  // Third half-band stage setting
  typedef struct packed {
    logic [5:0] mode;
    logic       skip;
  } nfcr_stage_t;
  // Phase trims of the two paths
  typedef struct packed {
    logic [9:0] iTrim;
    logic [9:0] qTrim;
  } nfcr_trim_t;
endpackage
`default_nettype wire

// *** hw/nfcr_regs.sv ***
// AXI4-Lite register bank for the carrier oscillator and third filter stage
//
// The AXI4-Lite register port was left to the implementer.
`include "nfcr_consts.svh"
`default_nettype none
module nfcr_regs
  import nfcr_pkg::*;
#(
  parameter int         ADDR_W  = 10,
  parameter logic [7:0] PART_ID = 8'hA5  // Arbitrary identification value
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              syncStrobe,
  input  wire logic [15:0]       iSampleIn,
  input  wire logic              iSampleValid,
  output logic [15:0]            iSampleOut,
  output logic                   iSampleOutValid,
  output nfcr_stage_t            stageCfg,
  output logic [2:0]             stageBand,
  output logic                   stageModulate,
  output logic [31:0]            oscTuningWord,
  output logic [15:0]            oscPhase,
  output nfcr_trim_t             trimCfg,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [6:0]        stageCtl_r;
  logic [31:0]       twStage_r;
  logic [15:0]       phaseOff_r;
  logic              updReq_r;
  logic              updReqPrev_r;
  logic              updAck_r;
  logic              syncArm_r;
  logic              syncDone_r;
  logic [9:0]        iTrim_r;
  logic [9:0]        qTrim_r;
  logic [15:0]       iOff_r;
  logic [1:0]        irqStat_r;
  logic [1:0]        irqMask_r;
  logic [31:0]       acc_r;
  logic [2:0]        syncSh_r;
  logic              syncLvl_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [7:0]        wByte_r;
  logic              wLane_r;
  logic              awHeld_r;
  logic              wHeld_r;

  // Decode helpers, shared by the write and read paths
  function automatic logic isMapped(input logic [7:0] idx);
    if (idx == `NFCR_IDX_STAGE || idx == `NFCR_IDX_ID) begin
      return 1'b1;
    end else if (idx >= `NFCR_IDX_TW0 && idx <= `NFCR_IDX_UPD) begin
      return 1'b1;
    end else if (idx >= `NFCR_IDX_ITRIM_LO && idx <= `NFCR_IDX_IOFF_HI) begin
      return 1'b1;
    end else if (idx == `NFCR_IDX_IRQ_ST || idx == `NFCR_IDX_IRQ_MSK) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [7:0] idxOf(input logic [ADDR_W-1:0] a);
    return 8'(a[ADDR_W-1:2]);
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------------
  logic       wrFire;
  logic       wrEn;
  logic [7:0] wrIdx;
  logic       ldEvt;
  logic       oscReset;
  logic       syncEdge;
  assign wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
  assign wrIdx  = idxOf(awAddr_r);
  // Only lane zero carries the eight-bit registers
  assign wrEn   = wrFire && wLane_r && isMapped(wrIdx);

  // Address and data are taken in either order and held until both are in
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= '0;
      wByte_r       <= `NFCR_RST_BYTE;
      wLane_r       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `NFCR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r      <= s_axi_awaddr;
        awHeld_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wByte_r      <= s_axi_wdata[7:0];
        wLane_r      <= s_axi_wstrb[0];
        wHeld_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(wrIdx) ? `NFCR_RESP_OKAY : `NFCR_RESP_SLVERR;
      end
      // Ready returns only after the response so one write is under way
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Plain configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stageCtl_r <= 7'h00;
      twStage_r  <= 32'h0000_0000;
      phaseOff_r <= 16'h0000;
      iTrim_r    <= 10'h000;
      qTrim_r    <= 10'h000;
      iOff_r     <= 16'h0000;
      irqMask_r  <= 2'h0;
    end else if (wrEn) begin
      if (wrIdx == `NFCR_IDX_STAGE) begin
        stageCtl_r <= wByte_r[6:0];  // R1 R4
      end else if (wrIdx == `NFCR_IDX_TW0) begin
        twStage_r[7:0] <= wByte_r;  // R6
      end else if (wrIdx == `NFCR_IDX_TW1) begin
        twStage_r[15:8] <= wByte_r;  // R6
      end else if (wrIdx == `NFCR_IDX_TW2) begin
        twStage_r[23:16] <= wByte_r;  // R6
      end else if (wrIdx == `NFCR_IDX_TW3) begin
        twStage_r[31:24] <= wByte_r;  // R6
      end else if (wrIdx == `NFCR_IDX_PH_LO) begin
        phaseOff_r[7:0] <= wByte_r;
      end else if (wrIdx == `NFCR_IDX_PH_HI) begin
        phaseOff_r[15:8] <= wByte_r;
      end else if (wrIdx == `NFCR_IDX_ITRIM_LO) begin
        iTrim_r[7:0] <= wByte_r;  // R13
      end else if (wrIdx == `NFCR_IDX_ITRIM_HI) begin
        iTrim_r[9:8] <= wByte_r[1:0];  // R13
      end else if (wrIdx == `NFCR_IDX_QTRIM_LO) begin
        qTrim_r[7:0] <= wByte_r;  // R14
      end else if (wrIdx == `NFCR_IDX_QTRIM_HI) begin
        qTrim_r[9:8] <= wByte_r[1:0];  // R14
      end else if (wrIdx == `NFCR_IDX_IOFF_LO) begin
        iOff_r[7:0] <= wByte_r;  // R15
      end else if (wrIdx == `NFCR_IDX_IOFF_HI) begin
        iOff_r[15:8] <= wByte_r;  // R15
      end else if (wrIdx == `NFCR_IDX_IRQ_MSK) begin
        irqMask_r <= wByte_r[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tuning word load handshake
  // ----------------------------------------------------------------------
  logic updWr;
  assign updWr = wrEn && wrIdx == `NFCR_IDX_UPD;
  // Edge detection means a request held high never loads twice
  assign ldEvt = updReq_r && !updReqPrev_r;  // R7 R16

  // Request bit, its delayed copy and the done flag; load beats a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      updReq_r      <= 1'b0;
      updReqPrev_r  <= 1'b0;
      updAck_r      <= 1'b0;
      oscTuningWord <= 32'h0000_0000;
    end else begin
      if (updWr) begin
        updReq_r <= wByte_r[`NFCR_BIT_UPD_REQ];  // R8
      end
      updReqPrev_r <= updReq_r;
      if (ldEvt) begin
        oscTuningWord <= twStage_r;  // R7 R8
        updAck_r      <= 1'b1;  // R9
      end else if (updWr && !wByte_r[`NFCR_BIT_UPD_REQ]) begin
        updAck_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sync strobe synchroniser and oscillator reset
  // ----------------------------------------------------------------------
  // Stage 0 feeds stage 1 only; the level moves once stages 1 and 2 agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncSh_r  <= 3'h0;
      syncLvl_r <= 1'b0;
    end else begin
      syncSh_r <= {syncSh_r[1:0], syncStrobe};
      if (syncSh_r[1] == syncSh_r[2]) begin
        syncLvl_r <= syncSh_r[2];
      end
    end
  end

  assign syncEdge = (syncSh_r[1] == syncSh_r[2]) && syncSh_r[2] && !syncLvl_r;
  assign oscReset = syncEdge && syncArm_r;  // R10

  // Arm is consumed by the reset; a software set in the same cycle wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncArm_r  <= 1'b0;
      syncDone_r <= 1'b0;
    end else begin
      if (updWr && wByte_r[`NFCR_BIT_SYN_ARM]) begin
        syncArm_r <= 1'b1;
      end else if (updWr || oscReset) begin
        syncArm_r <= 1'b0;  // R10
      end
      if (oscReset) begin
        syncDone_r <= 1'b1;  // R11
      end else if (updWr && wByte_r[`NFCR_BIT_SYN_ARM]) begin
        syncDone_r <= 1'b0;
      end
    end
  end

  // Phase accumulator; a reset restarts it from the programmed phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r    <= 32'h0000_0000;
      oscPhase <= 16'h0000;
    end else begin
      if (oscReset) begin
        acc_r <= {phaseOff_r, 16'h0000};  // R12
      end else begin
        acc_r <= acc_r + oscTuningWord;
      end
      oscPhase <= acc_r[31:16];
    end
  end

  // ----------------------------------------------------------------------
  // Datapath-facing outputs
  // ----------------------------------------------------------------------
  // Mode codes repeat their low three bits; bit 2 of the band means modulated
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stageCfg        <= '0;
      stageBand       <= 3'h0;
      stageModulate   <= 1'b0;
      trimCfg         <= '0;
      iSampleOut      <= 16'h0000;
      iSampleOutValid <= 1'b0;
    end else begin
      stageCfg.mode   <= stageCtl_r[6:1];  // R1
      stageCfg.skip   <= stageCtl_r[`NFCR_BIT_SKIP];  // R4
      stageBand       <= stageCtl_r[3:1];  // R2 R3
      stageModulate   <= stageCtl_r[6];  // R3
      trimCfg.iTrim   <= iTrim_r;  // R13
      trimCfg.qTrim   <= qTrim_r;  // R14
      iSampleOutValid <= iSampleValid;
      if (iSampleValid) begin
        iSampleOut <= iSampleIn + iOff_r;  // R15
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------------
  logic [1:0] stClr;
  assign stClr = (wrEn && wrIdx == `NFCR_IDX_IRQ_ST) ? wByte_r[1:0] : 2'h0;

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= 2'h0;
      irq       <= 1'b0;
    end else begin
      irqStat_r[`NFCR_ST_LOAD] <= ldEvt | (irqStat_r[`NFCR_ST_LOAD] & ~stClr[0]);
      irqStat_r[`NFCR_ST_SYNC] <= oscReset | (irqStat_r[`NFCR_ST_SYNC] & ~stClr[1]);
      irq <= |(irqStat_r & irqMask_r);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rdMux(input logic [7:0] idx);
    if (idx == `NFCR_IDX_STAGE) begin
      return {1'b0, stageCtl_r};
    end else if (idx == `NFCR_IDX_ID) begin
      return PART_ID;  // R5
    end else if (idx == `NFCR_IDX_TW0) begin
      return twStage_r[7:0];
    end else if (idx == `NFCR_IDX_TW1) begin
      return twStage_r[15:8];
    end else if (idx == `NFCR_IDX_TW2) begin
      return twStage_r[23:16];
    end else if (idx == `NFCR_IDX_TW3) begin
      return twStage_r[31:24];
    end else if (idx == `NFCR_IDX_PH_LO) begin
      return phaseOff_r[7:0];
    end else if (idx == `NFCR_IDX_PH_HI) begin
      return phaseOff_r[15:8];
    end else if (idx == `NFCR_IDX_UPD) begin
      return {2'h0, syncDone_r, syncArm_r, 2'h0, updAck_r, updReq_r};
    end else if (idx == `NFCR_IDX_ITRIM_LO) begin
      return iTrim_r[7:0];
    end else if (idx == `NFCR_IDX_ITRIM_HI) begin
      return {6'h00, iTrim_r[9:8]};
    end else if (idx == `NFCR_IDX_QTRIM_LO) begin
      return qTrim_r[7:0];
    end else if (idx == `NFCR_IDX_QTRIM_HI) begin
      return {6'h00, qTrim_r[9:8]};
    end else if (idx == `NFCR_IDX_IOFF_LO) begin
      return iOff_r[7:0];
    end else if (idx == `NFCR_IDX_IOFF_HI) begin
      return iOff_r[15:8];
    end else if (idx == `NFCR_IDX_IRQ_ST) begin
      return {6'h00, irqStat_r};
    end else if (idx == `NFCR_IDX_IRQ_MSK) begin
      return {6'h00, irqMask_r};
    end else begin
      return 8'h00;
    end
  endfunction

  // One read at a time; data is captured when the address is taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `NFCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rdMux(idxOf(s_axi_araddr))};
      s_axi_rresp   <= isMapped(idxOf(s_axi_araddr)) ? `NFCR_RESP_OKAY : `NFCR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_mode_band;
    ##1 (stageCfg.mode == $past(stageCtl_r[6:1])) && (stageBand == $past(stageCtl_r[3:1]))
        && (stageModulate == $past(stageCtl_r[6]));
  endproperty
  a_mode_band: assert property (p_mode_band) else $error("mode outputs wrong"); // R1
  property p_modulate;
    ##1 (stageBand[2] == stageModulate) || !$past(stageCtl_r[6:4] == stageCtl_r[3:1]);
  endproperty
  a_modulate: assert property (p_modulate) else $error("modulate flag wrong"); // R3
  property p_skip;
    wrEn && wrIdx == `NFCR_IDX_STAGE |-> ##2 stageCfg.skip == $past(wByte_r[0], 2);
  endproperty
  a_skip: assert property (p_skip) else $error("skip bit not applied"); // R4
  property p_id;
    s_axi_arvalid && s_axi_arready && idxOf(s_axi_araddr) == `NFCR_IDX_ID
      |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, PART_ID};
  endproperty
  a_id: assert property (p_id) else $error("identity read wrong"); // R5
  property p_staged;
    !ldEvt |=> $stable(oscTuningWord);
  endproperty
  a_staged: assert property (p_staged) else $error("tuning changed without load"); // R7
  property p_load;
    $rose(updReq_r) |=> oscTuningWord == $past(twStage_r) && updAck_r;
  endproperty
  a_load: assert property (p_load) else $error("tuning load failed"); // R8
  property p_ack;
    ldEvt |=> updAck_r && irqStat_r[`NFCR_ST_LOAD];
  endproperty
  a_ack: assert property (p_ack) else $error("load done not set"); // R9
  property p_no_repeat;
    updReq_r && updReqPrev_r |=> $stable(oscTuningWord);
  endproperty
  a_no_repeat: assert property (p_no_repeat) else $error("repeated load"); // R16
  property p_sync_reset;
    syncEdge && syncArm_r |=> syncDone_r ##1 acc_r == 32'($past(acc_r) + $past(oscTuningWord));
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync reset missed"); // R11
  property p_unarmed;
    !syncArm_r |=> acc_r == 32'($past(acc_r) + $past(oscTuningWord));
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("unarmed reset"); // R10
  property p_phase;
    oscReset |=> acc_r == {$past(phaseOff_r), 16'h0000};
  endproperty
  a_phase: assert property (p_phase) else $error("start phase not loaded"); // R12
  property p_offset;
    iSampleValid |=> iSampleOutValid && iSampleOut == 16'($past(iSampleIn) + $past(iOff_r));
  endproperty
  a_offset: assert property (p_offset) else $error("offset sum wrong"); // R15
  property p_trim;
    ##2 trimCfg == {$past(iTrim_r, 1), $past(qTrim_r, 1)};
  endproperty
  a_trim: assert property (p_trim) else $error("trim not applied"); // R13 R14

  c_load: cover property (ldEvt ##1 updAck_r);
  c_sync: cover property (oscReset ##1 syncDone_r);
  c_irq: cover property ($rose(irq));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == `NFCR_RESP_SLVERR);

endmodule
`default_nettype wire

// *** tb/nfcr_regs_test.sv ***
// Self-checking bench of the oscillator and filter control register bank
`default_nettype none
module nfcr_regs_test import nfcr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------
  localparam logic [7:0] PART_CODE = 8'h3C;  // Arbitrary identification value
  logic        core_clk = 1'b0, rst_n = 1'b0;
  logic [9:0]  awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, rData, tw, seed = 32'h0000000D;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, sOutValid, stageMod, irq;
  logic        syncStrobe = 1'b0, iSampleValid = 1'b0;
  logic [15:0] iSampleIn = '0, sOut, oscPhase;
  logic [1:0]  bResp, rResp;
  logic [2:0]  stageBand;
  logic [3:0]  wStrb = 4'hF;
  nfcr_stage_t stageCfg;
  nfcr_trim_t  trimCfg;
  logic [33:0] rdQ[$];
  logic [1:0]  wrQ[$];
  logic [15:0] smpQ[$];
  logic [7:0]  rstIdx[8] = '{8'h1E, 8'h30, 8'h33, 8'h35, 8'h36, 8'h39, 8'h3D, 8'h51};
  int          failCount = 0, checksDone = 0, cyc = 0;

  nfcr_regs #(.PART_ID(PART_CODE)) i_nfcr_regs (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .syncStrobe(syncStrobe), .iSampleIn(iSampleIn), .iSampleValid(iSampleValid),
    .iSampleOut(sOut), .iSampleOutValid(sOutValid), .stageCfg(stageCfg), .stageBand(stageBand),
    .stageModulate(stageMod), .oscTuningWord(tw), .oscPhase(oscPhase), .trimCfg(trimCfg),
    .irq(irq));

  // Free-running 20 MHz clock
  initial forever #25 core_clk = ~core_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string msg);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Write one register; address and data are released each when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
    wrQ.push_back(resp);
    awAddr <= {idx, 2'b00};
    wData <= {24'h000000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
    rdQ.push_back({resp, 24'h000000, d});
    arAddr <= {idx, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    @(posedge core_clk);
  endtask

  // Long strobe so the level filter sees an extended pulse
  task automatic pulse();
    syncStrobe <= 1'b1;
    wt(8);
    syncStrobe <= 1'b0;
    wt(8);
  endtask

  // Monitor: the oldest note is compared whenever a result appears
  always @(posedge core_clk) begin
    cyc++;
    if (bValid === 1'b1 && bReady && wrQ.size() > 0) chk(bResp, wrQ.pop_front(), "bresp");
    if (rValid === 1'b1 && rReady && rdQ.size() > 0) chk({rResp, rData}, rdQ.pop_front(), "rd");
    if (sOutValid === 1'b1 && smpQ.size() > 0) chk(sOut, smpQ.pop_front(), "sample");
    if (cyc == 4000) begin
      failCount++;
      giveVerdict();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [5:0]  code;
    logic [31:0] w, w2;
    wt(12);
    rst_n <= 1'b1;
    wt(1);
    // Reset values, read-only identity, unmapped index
    foreach (rstIdx[k]) rd(rstIdx[k], 8'h00, 2'h0);
    wr(8'h1F, 8'h5A, 2'h0);
    rd(8'h1F, PART_CODE, 2'h0);
    wr(8'h20, 8'hFF, 2'h2);
    rd(8'h20, 8'h00, 2'h2);
    // Eight third-stage mode codes with repeated low three bits, skip bit alternating
    for (int i = 0; i < 8; i++) begin
      code = {i[2:0], i[2:0]};
      wr(8'h1E, {1'b0, code, i[0]}, 2'h0);
      wt(3);
      chk(stageCfg, {code, i[0]}, "stage cfg");
      chk(stageBand, i[2:0], "band");
      chk(stageMod, i[2], "modulate");
      rd(8'h1E, {1'b0, code, i[0]}, 2'h0);
    end
    // Sync reset: unarmed pulse ignored, armed pulse loads start phase
    w = rnd();
    wr(8'h34, w[7:0], 2'h0);
    wr(8'h35, w[15:8], 2'h0);
    pulse();
    rd(8'h36, 8'h00, 2'h0);
    wr(8'h36, 8'h10, 2'h0);
    rd(8'h36, 8'h10, 2'h0);
    pulse();
    rd(8'h36, 8'h20, 2'h0);
    chk(oscPhase, w[15:0], "start phase");
    chk(irq, 1'b0, "masked irq");
    wr(8'h51, 8'h02, 2'h0);
    wt(3);
    chk(irq, 1'b1, "unmasked irq");
    wr(8'h50, 8'h02, 2'h0);
    wt(3);
    chk(irq, 1'b0, "cleared irq");
    // Tuning word staged, loaded on rising request, not reloaded while held
    wr(8'h51, 8'h03, 2'h0);
    w = rnd();
    for (int k = 0; k < 4; k++) wr(8'h30 + k[7:0], w[8*k +: 8], 2'h0);
    wt(3);
    chk(tw, 32'h00000000, "staged only");
    wr(8'h36, 8'h01, 2'h0);
    wt(3);
    chk(tw, w, "loaded word");
    chk(irq, 1'b1, "load irq");
    rd(8'h36, 8'h23, 2'h0);
    w2 = rnd();
    for (int k = 0; k < 4; k++) wr(8'h30 + k[7:0], w2[8*k +: 8], 2'h0);
    wr(8'h36, 8'h01, 2'h0);
    wt(3);
    chk(tw, w, "held request");
    wr(8'h36, 8'h00, 2'h0);
    rd(8'h36, 8'h20, 2'h0);
    wr(8'h36, 8'h01, 2'h0);
    wt(3);
    chk(tw, w2, "second load");
    rd(8'h33, w2[31:24], 2'h0);
    wr(8'h50, 8'h03, 2'h0);
    wt(3);
    chk(irq, 1'b0, "irq cleared");
    // Phase trims: only the two low bits of each upper byte count
    w = rnd();
    wr(8'h38, w[7:0], 2'h0);
    wr(8'h39, w[15:8], 2'h0);
    wr(8'h3A, w[17:10], 2'h0);
    wr(8'h3B, w[25:18], 2'h0);
    wt(3);
    chk(trimCfg, {w[9:0], w[19:10]}, "trims");
    // Lane zero strobe off: answered, but the register keeps its value
    wStrb <= 4'h0;
    wr(8'h3C, 8'hFF, 2'h0);
    wStrb <= 4'hF;
    rd(8'h3C, 8'h00, 2'h0);
    // Offset added to back-to-back samples, wrapping
    w = rnd();
    wr(8'h3C, w[7:0], 2'h0);
    wr(8'h3D, w[15:8], 2'h0);
    wt(3);
    for (int k = 0; k < 5; k++) begin
      w2 = rnd();
      iSampleIn <= w2[15:0];
      iSampleValid <= 1'b1;
      smpQ.push_back(w2[15:0] + w[15:0]);
      @(posedge core_clk);
    end
    iSampleValid <= 1'b0;
    wt(4);
    chk(rdQ.size() + wrQ.size() + smpQ.size(), 0, "pending notes");
    giveVerdict();
  end
endmodule
`default_nettype wire
